// >>> logic/clock_ctrl_pkg.sv
// Purpose: Shared constants and types of the clock generation control block.
// Assumes: One core clock at 25 MHz; registers reached over a plain strobe port.
// Notes: Offsets, source and standby fields, reset values and wait counts live here only.
package clock_ctrl_pkg;
  // Register byte addresses on the strobe port.
  localparam logic [7:0] clock_source_addr = 8'h00;
  localparam logic [7:0] standby_control_addr = 8'h04;
  localparam logic [7:0] clock_divide_a_addr = 8'h08;
  localparam logic [7:0] clock_divide_b_addr = 8'h0c;
  localparam logic [7:0] clock_status_addr = 8'h10;
  // Clock source register fields.
  localparam int source_sel_lsb = 0;
  localparam int main_pll_enable_bit = 10;
  localparam int sub_pll_enable_bit = 11;
  localparam int main_pll_rate_lsb = 12;
  // Standby control register fields.
  localparam int stop_osc_halt_a_bit = 0;
  localparam int stop_osc_halt_b_bit = 1;
  localparam int stab_wait_select_lsb = 2;
  localparam int stop_request_bit = 7;
  // Reset values.
  localparam logic [15:0] clock_source_reset = 16'h0000;
  localparam logic [15:0] standby_control_reset = 16'h0003;
  localparam logic [15:0] clock_divide_a_reset = 16'h0000;
  localparam logic [15:0] clock_divide_b_reset = 16'h0000;
  // Stabilization waits in core cycles, one per select code.
  localparam logic [12:0] stab_wait_0 = 13'h0100;
  localparam logic [12:0] stab_wait_1 = 13'h0200;
  localparam logic [12:0] stab_wait_2 = 13'h0400;
  localparam logic [12:0] stab_wait_3 = 13'h1000;
  // Source selection codes; the fourth code is not a source.
  typedef enum logic [1:0] {src_main_half, src_main_pll, src_sub} src_sel_type;
  // Four 4-bit divider settings, channel 0 in the low nibble.
  typedef struct packed {
    logic [3:0][3:0] setting;
  } div_cfg_type;
  // Divided clocks as levels plus one-cycle rising-edge ticks.
  typedef struct packed {
    logic [3:0] level;
    logic [3:0] tick;
  } clk_bundle_type;
endpackage

// >>> logic/clock_divider.sv
// Purpose: Divides the base clock into four internal clocks.
// Assumes: half_en_i pulses once per half period of the base clock.
// Notes: Counting half periods gives exact 50% duty for odd ratios.
`timescale 1ns/1ps
module clock_divider
  import clock_ctrl_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic half_en_i,
  input wire div_cfg_type cfg_i,
  output clk_bundle_type clocks_o
);
  logic [3:0][3:0] count; // Half periods spent in the current phase.
  logic [3:0][3:0] next_count;
  clk_bundle_type next_clocks;

  // Each phase lasts setting plus one half periods of the base clock.
  always_comb begin
    next_count = count;
    next_clocks.level = clocks_o.level;
    next_clocks.tick = 4'h0;
    for (int i = 0; i < 4; i++) begin
      if (half_en_i) begin
        // A shrunk setting below the running count ends the phase at once.
        if (count[i] >= cfg_i.setting[i]) begin
          next_count[i] = 4'h0;
          next_clocks.level[i] = ~clocks_o.level[i];
          next_clocks.tick[i] = ~clocks_o.level[i];
        end else begin
          next_count[i] = count[i] + 4'h1;
        end
      end
    end
  end

  // Registers only.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      count <= '0;
      clocks_o <= '0;
    end else begin
      count <= next_count;
      clocks_o <= next_clocks;
    end
  end

  a_tick_on_rise: assert property (@(posedge core_clk_i) disable iff (reset_i)
    clocks_o.tick[0] |-> clocks_o.level[0] && !$past(clocks_o.level[0]))
    else $error("Tick without a rising level.");
  a_ratio_one: assert property (@(posedge core_clk_i) disable iff (reset_i)
    half_en_i && cfg_i.setting[1] == 4'h0 && $stable(cfg_i) |=>
    clocks_o.level[1] != $past(clocks_o.level[1]))
    else $error("Ratio one did not toggle on every half period.");
endmodule // clock_divider

// >>> logic/clock_switch.sv
// Purpose: Glitch-free selection of the base clock source.
// Assumes: Source half-period pulses come from the core clock domain.
// Notes: A switch waits for the old falling half, then skips one new half.
`timescale 1ns/1ps
module clock_switch
  import clock_ctrl_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic [1:0] sel_i,
  input wire logic gate_i,
  input wire logic pll_half_i,
  input wire logic sub_half_i,
  output logic half_en_o,
  output logic level_o,
  output logic [1:0] active_o
);
  typedef enum logic {sw_run, sw_settle} sw_state_type;
  sw_state_type state;
  sw_state_type next_state;
  logic next_half_en;
  logic next_level;
  logic [1:0] next_active;
  logic tick; // Half period of the active source.

  // Half-period pulse of a source; main/2 halves once per core cycle.
  function automatic logic src_half(input logic [1:0] s, input logic p, input logic b);
    if (s == 2'(src_main_pll)) return p;
    else if (s == 2'(src_sub)) return b;
    else return 1'b1;
  endfunction

  // The old source leaves only on a falling half, so no high pulse is cut.
  always_comb begin
    tick = src_half(active_o, pll_half_i, sub_half_i) && !gate_i;
    next_state = state;
    next_half_en = 1'b0;
    next_level = level_o;
    next_active = active_o;
    case (state)
      sw_run: begin
        if (tick) begin
          next_half_en = 1'b1;
          next_level = ~level_o;
          if (level_o && sel_i != active_o) begin
            next_active = sel_i;
            next_state = sw_settle;
          end
        end
      end
      default: begin
        // Low stays for one whole half of the new source before rising.
        if (src_half(active_o, pll_half_i, sub_half_i) && !gate_i) begin
          next_state = sw_run;
        end
      end
    endcase
  end

  // Registers only.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state <= sw_run;
      half_en_o <= 1'b0;
      level_o <= 1'b0;
      active_o <= 2'(src_main_half);
    end else begin
      state <= next_state;
      half_en_o <= next_half_en;
      level_o <= next_level;
      active_o <= next_active;
    end
  end

  a_settle_low: assert property (@(posedge core_clk_i) disable iff (reset_i)
    state == sw_settle |-> !level_o ##1 !half_en_o)
    else $error("Base clock high while settling on a new source.");
  a_switch_falls: assert property (@(posedge core_clk_i) disable iff (reset_i)
    active_o != $past(active_o) |-> !level_o && $past(level_o))
    else $error("Source changed outside a falling half.");
endmodule // clock_switch

// >>> logic/clock_gen_control.sv
// Purpose: Clock source, PLL, stop-mode and stabilization-wait control.
// Assumes: reset_i is the settings initialization reset; pll_half_i is same-clock.
// Notes: Program execution is held through cpu_halt_o during any wait.
//
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module clock_gen_control
  import clock_ctrl_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [15:0] reg_rdata_o,
  input wire logic pll_half_i,
  input wire logic sub_osc_i,
  input wire logic wake_i,
  output logic base_clk_o,
  output logic [3:0] clk_level_o,
  output logic [3:0] clk_tick_o,
  output logic cpu_halt_o,
  output logic stop_mode_o,
  output logic main_pll_run_o,
  output logic sub_pll_run_o,
  output logic [2:0] pll_rate_o
);
  typedef enum logic [1:0] {st_stab, st_run, st_stop} ctl_state_type;

  // Register state.
  logic [1:0] source_sel; // Selected source code.
  logic main_pll_enable; // Software enable of the main PLL.
  logic sub_pll_enable; // Software enable of the sub oscillation path.
  logic [2:0] main_pll_rate; // Multiplication rate.
  logic stop_osc_halt_a; // Stop mode halts the main oscillator and PLL.
  logic stop_osc_halt_b; // Stop mode halts the sub oscillator path.
  logic [1:0] stab_wait_select; // One of four wait lengths.
  div_cfg_type div_cfg; // Divider settings of the four clocks.
  logic [1:0] next_source_sel;
  logic next_main_pll_enable;
  logic next_sub_pll_enable;
  logic [2:0] next_main_pll_rate;
  logic next_stop_osc_halt_a;
  logic next_stop_osc_halt_b;
  logic [1:0] next_stab_wait_select;
  div_cfg_type next_div_cfg;
  logic [15:0] next_reg_rdata;

  // Control state.
  ctl_state_type state;
  ctl_state_type next_state;
  logic [12:0] wait_count; // Remaining stabilization cycles.
  logic [12:0] next_wait_count;
  logic next_main_pll_run;
  logic next_sub_pll_run;

  // Sub oscillator pin synchronizer; a change counts while stages 2 and 3 differ.
  logic [2:0] sub_sync;
  logic sub_half; // One pulse per sub oscillator half period.

  // Internal wires from the sub-modules.
  logic base_half_en;
  logic base_level;
  logic [1:0] active_sel;
  clk_bundle_type clocks;

  // Wait length for a select code, used at stop return and rate change; reset release loads stab_wait_0.
  function automatic logic [12:0] wait_len(input logic [1:0] code);
    if (code == 2'h0) return stab_wait_0;
    else if (code == 2'h1) return stab_wait_1;
    else if (code == 2'h2) return stab_wait_2;
    else return stab_wait_3;
  endfunction

  // Chosen wait applies through the time-base count.
  logic is_src_write;
  logic is_stby_write;
  logic rate_change_on_pll;
  logic stop_entry;

  // Register writes and their side effects on selection and PLL control.
  always_comb begin
    is_src_write = reg_write_i && reg_addr_i == clock_source_addr;
    is_stby_write = reg_write_i && reg_addr_i == standby_control_addr;
    next_source_sel = source_sel;
    next_main_pll_enable = main_pll_enable;
    next_sub_pll_enable = sub_pll_enable;
    next_main_pll_rate = main_pll_rate;
    next_stop_osc_halt_a = stop_osc_halt_a;
    next_stop_osc_halt_b = stop_osc_halt_b;
    next_stab_wait_select = stab_wait_select;
    next_div_cfg = div_cfg;
    rate_change_on_pll = 1'b0;
    stop_entry = 1'b0;
    if (is_src_write) begin
      next_main_pll_enable = reg_wdata_i[main_pll_enable_bit];
      next_sub_pll_enable = reg_wdata_i[sub_pll_enable_bit];
      next_main_pll_rate = reg_wdata_i[main_pll_rate_lsb +: 3];
      // A selected PLL cannot be switched off; the write keeps it running.
      if (source_sel == 2'(src_main_pll)) begin
        next_main_pll_enable = 1'b1;
      end
      // Only a running PLL may become the source; code 3 is no source.
      if (reg_wdata_i[source_sel_lsb +: 2] == 2'(src_main_pll)) begin
        if (next_main_pll_enable && main_pll_enable) begin
          next_source_sel = 2'(src_main_pll);
        end
      end else if (reg_wdata_i[source_sel_lsb +: 2] != 2'h3) begin
        next_source_sel = reg_wdata_i[source_sel_lsb +: 2];
      end
      // Changing the rate under a live PLL source forces a new wait.
      if (source_sel == 2'(src_main_pll)) begin
        rate_change_on_pll = next_main_pll_rate != main_pll_rate;
      end
    end else if (is_stby_write) begin
      next_stop_osc_halt_a = reg_wdata_i[stop_osc_halt_a_bit];
      next_stop_osc_halt_b = reg_wdata_i[stop_osc_halt_b_bit];
      next_stab_wait_select = reg_wdata_i[stab_wait_select_lsb +: 2];
      stop_entry = reg_wdata_i[stop_request_bit];
    end else if (reg_write_i && reg_addr_i == clock_divide_a_addr) begin
      next_div_cfg.setting[1:0] = reg_wdata_i[7:0];
    end else if (reg_write_i && reg_addr_i == clock_divide_b_addr) begin
      next_div_cfg.setting[3:2] = reg_wdata_i[7:0];
    end
  end

  // Read data stand in the cycle after the read strobe; others read zero.
  always_comb begin
    next_reg_rdata = 16'h0000;
    if (reg_read_i && reg_addr_i == clock_source_addr) begin
      next_reg_rdata[source_sel_lsb +: 2] = source_sel;
      next_reg_rdata[main_pll_enable_bit] = main_pll_enable;
      next_reg_rdata[sub_pll_enable_bit] = sub_pll_enable;
      next_reg_rdata[main_pll_rate_lsb +: 3] = main_pll_rate;
    end else if (reg_read_i && reg_addr_i == standby_control_addr) begin
      next_reg_rdata[stop_osc_halt_a_bit] = stop_osc_halt_a;
      next_reg_rdata[stop_osc_halt_b_bit] = stop_osc_halt_b;
      next_reg_rdata[stab_wait_select_lsb +: 2] = stab_wait_select;
    end else if (reg_read_i && reg_addr_i == clock_divide_a_addr) begin
      next_reg_rdata[7:0] = div_cfg.setting[1:0];
    end else if (reg_read_i && reg_addr_i == clock_divide_b_addr) begin
      next_reg_rdata[7:0] = div_cfg.setting[3:2];
    end else if (reg_read_i && reg_addr_i == clock_status_addr) begin
      next_reg_rdata[0] = state == st_stab;
      next_reg_rdata[1] = state == st_stop;
      next_reg_rdata[2] = main_pll_run_o;
      next_reg_rdata[3] = sub_pll_run_o;
      next_reg_rdata[5:4] = active_sel;
    end
  end

  // Operating states: wait, run and stop, with PLL run levels.
  always_comb begin
    next_state = state;
    next_wait_count = wait_count;
    case (state)
      st_stab: begin
        // Program held and clocks gated until the time-base count ends.
        if (wait_count <= 13'h0001) begin
          next_state = st_run;
          next_wait_count = 13'h0000;
        end else begin
          next_wait_count = wait_count - 13'h0001;
        end
      end
      st_run: begin
        if (stop_entry) begin
          next_state = st_stop;
        end else if (rate_change_on_pll) begin
          next_state = st_stab;
          next_wait_count = wait_len(next_stab_wait_select);
        end
        // Without a PLL source, PLL writes leave the program running.
      end
      default: begin
        // Wake replays the wait that software programmed beforehand.
        if (wake_i) begin
          next_state = st_stab;
          next_wait_count = wait_len(stab_wait_select);
        end
      end
    endcase
    // Halting oscillators take their PLL down in stop; a running one does not.
    next_main_pll_run = next_main_pll_enable &&
      !(next_state == st_stop && next_stop_osc_halt_a);
    next_sub_pll_run = next_sub_pll_enable &&
      !(next_state == st_stop && next_stop_osc_halt_b);
  end

  // All registered state; reset release enters the wait with PLLs off.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      source_sel <= clock_source_reset[source_sel_lsb +: 2];
      main_pll_enable <= clock_source_reset[main_pll_enable_bit];
      sub_pll_enable <= clock_source_reset[sub_pll_enable_bit];
      main_pll_rate <= clock_source_reset[main_pll_rate_lsb +: 3];
      stop_osc_halt_a <= standby_control_reset[stop_osc_halt_a_bit];
      stop_osc_halt_b <= standby_control_reset[stop_osc_halt_b_bit];
      stab_wait_select <= standby_control_reset[stab_wait_select_lsb +: 2];
      div_cfg.setting[1:0] <= clock_divide_a_reset[7:0];
      div_cfg.setting[3:2] <= clock_divide_b_reset[7:0];
      state <= st_stab;
      wait_count <= stab_wait_0;
      reg_rdata_o <= 16'h0000;
      main_pll_run_o <= 1'b0;
      sub_pll_run_o <= 1'b0;
      cpu_halt_o <= 1'b1;
      stop_mode_o <= 1'b0;
      pll_rate_o <= 3'h0;
      sub_sync <= 3'h0;
    end else begin
      source_sel <= next_source_sel;
      main_pll_enable <= next_main_pll_enable;
      sub_pll_enable <= next_sub_pll_enable;
      main_pll_rate <= next_main_pll_rate;
      stop_osc_halt_a <= next_stop_osc_halt_a;
      stop_osc_halt_b <= next_stop_osc_halt_b;
      stab_wait_select <= next_stab_wait_select;
      div_cfg <= next_div_cfg;
      state <= next_state;
      wait_count <= next_wait_count;
      reg_rdata_o <= next_reg_rdata;
      main_pll_run_o <= next_main_pll_run;
      sub_pll_run_o <= next_sub_pll_run;
      cpu_halt_o <= next_state != st_run;
      stop_mode_o <= next_state == st_stop;
      pll_rate_o <= next_main_pll_rate;
      sub_sync <= {sub_sync[1:0], sub_osc_i};
    end
  end

  // Only stages 2 and 3 of the synchronizer are compared.
  assign sub_half = sub_sync[2] != sub_sync[1];

  // Glitch-free source switch; clocks stop while waiting or stopped.
  clock_switch u_switch (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .sel_i(source_sel),
    .gate_i(state != st_run),
    .pll_half_i(pll_half_i),
    .sub_half_i(sub_half),
    .half_en_o(base_half_en),
    .level_o(base_level),
    .active_o(active_sel)
  );

  // Four internal clocks divided from the base clock halves.
  clock_divider u_divider (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .half_en_i(base_half_en),
    .cfg_i(div_cfg),
    .clocks_o(clocks)
  );

  assign base_clk_o = base_level;
  assign clk_level_o = clocks.level;
  assign clk_tick_o = clocks.tick;

  a_pll_needs_enable: assert property (@(posedge core_clk_i) disable iff (reset_i)
    source_sel == 2'(src_main_pll) |-> main_pll_enable)
    else $error("PLL selected while disabled.");
  a_pll_kept_on: assert property (@(posedge core_clk_i) disable iff (reset_i)
    source_sel == 2'(src_main_pll) && is_src_write |=> main_pll_enable && main_pll_run_o)
    else $error("Selected PLL was switched off.");
  a_rate_wait: assert property (@(posedge core_clk_i) disable iff (reset_i)
    state == st_run && !stop_entry && rate_change_on_pll |=> cpu_halt_o [*3])
    else $error("Rate change under PLL source did not halt.");
  a_rate_no_halt: assert property (@(posedge core_clk_i) disable iff (reset_i)
    state == st_run && is_src_write && source_sel != 2'(src_main_pll) |=> !cpu_halt_o)
    else $error("PLL change halted a non-PLL program.");
  a_stop_halts_pll: assert property (@(posedge core_clk_i) disable iff (reset_i)
    stop_mode_o && stop_osc_halt_a |-> !main_pll_run_o)
    else $error("Main PLL ran in stop with oscillator halt.");
  a_stop_keeps_pll: assert property (@(posedge core_clk_i) disable iff (reset_i)
    stop_mode_o && !stop_osc_halt_a && main_pll_enable |-> main_pll_run_o)
    else $error("Main PLL stopped although oscillator runs.");
  a_wake_wait: assert property (@(posedge core_clk_i) disable iff (reset_i)
    state == st_stop && wake_i && stab_wait_select == 2'h0 |=>
    cpu_halt_o && !stop_mode_o ##256 !cpu_halt_o)
    else $error("Wake wait length differs from the programmed one.");
  a_reset_wait: assert property (@(posedge core_clk_i)
    reset_i ##1 !reset_i [*2] |-> cpu_halt_o && !main_pll_run_o && !sub_pll_run_o)
    else $error("Reset release did not wait with PLLs off.");
  a_pll_src_run: assert property (@(posedge core_clk_i) disable iff (reset_i)
    active_sel == 2'(src_main_pll) && state == st_run |-> main_pll_run_o)
    else $error("Base clock taken from a stopped PLL.");
  // The first held cycle may still carry a half launched before the gate closed.
  a_sub_stop_halt: assert property (@(posedge core_clk_i) disable iff (reset_i)
    stop_mode_o && stop_osc_halt_b |-> !sub_pll_run_o)
    else $error("Sub path ran in stop with oscillator halt.");
  a_gated_in_wait: assert property (@(posedge core_clk_i) disable iff (reset_i)
    cpu_halt_o && $past(cpu_halt_o) |-> !base_half_en)
    else $error("Base clock advanced during a held wait.");

  c_pll_source: cover property (@(posedge core_clk_i) disable iff (reset_i)
    active_sel == 2'(src_main_pll));
  c_stop_wake: cover property (@(posedge core_clk_i) disable iff (reset_i)
    stop_mode_o ##1 !stop_mode_o);
  c_rate_wait: cover property (@(posedge core_clk_i) disable iff (reset_i)
    rate_change_on_pll && state == st_run);
  c_sub_source: cover property (@(posedge core_clk_i) disable iff (reset_i)
    active_sel == 2'(src_sub));
endmodule // clock_gen_control

// >>> tb/tb.sv
// Purpose: Self-checking bench for the clock generation control block.
// Assumes: Wait lengths and reset values as the package sets them.
// Notes: Halt lengths are counted from the cycle after the taking edge.
`timescale 1ns/1ps
module tb;
  import clock_ctrl_pkg::*;
  logic core_clk_i, reset_i, reg_write_i, reg_read_i, wake_i;
  logic pll_half_i = 1'b0, sub_osc_i = 1'b0;
  logic [7:0] reg_addr_i;
  logic [15:0] reg_wdata_i, reg_rdata_o, rd;
  logic base_clk_o, cpu_halt_o, stop_mode_o, main_pll_run_o, sub_pll_run_o;
  logic [3:0] clk_level_o, clk_tick_o;
  logic [2:0] pll_rate_o;
  int miscompares = 0, checks = 0, n, cyc = 0;
  // One row: write, expected readback and expected halt, main run and sub run flags.
  typedef struct {logic [7:0] a; logic [15:0] w; logic [15:0] r; logic [2:0] f;} row_type;
  row_type rows [8] = '{'{8'h00, 16'h0001, 16'h0000, 3'b000},
    '{8'h00, 16'h5400, 16'h5400, 3'b010}, '{8'h00, 16'h5401, 16'h5401, 3'b010},
    '{8'h00, 16'h5001, 16'h5401, 3'b010}, '{8'h00, 16'h5403, 16'h5401, 3'b010},
    '{8'h00, 16'h5C01, 16'h5C01, 3'b011}, '{8'h08, 16'h00A5, 16'h00A5, 3'b011},
    '{8'h20, 16'hFFFF, 16'h0000, 3'b011}};
  clock_gen_control DUT (.core_clk_i(core_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
    .reg_rdata_o(reg_rdata_o), .pll_half_i(pll_half_i), .sub_osc_i(sub_osc_i),
    .wake_i(wake_i), .base_clk_o(base_clk_o), .clk_level_o(clk_level_o),
    .clk_tick_o(clk_tick_o), .cpu_halt_o(cpu_halt_o), .stop_mode_o(stop_mode_o),
    .main_pll_run_o(main_pll_run_o), .sub_pll_run_o(sub_pll_run_o), .pll_rate_o(pll_rate_o));
  // The 25 MHz core clock.
  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end
  // Stand-in sources: PLL halves every other cycle, sub level slower.
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    pll_half_i <= ~pll_half_i;
    sub_osc_i <= cyc[2];
  end
  // Compares with case equality so an unknown never passes.
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1'b1;
    @(posedge core_clk_i);
    reg_write_i <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so they are caught there.
  task automatic rdr(input logic [7:0] a);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    @(posedge core_clk_i);
    reg_read_i <= 1'b0;
    #1 rd = reg_rdata_o;
  endtask
  // Counts the cycles of a held program, with a bound against a hang.
  task automatic halt_len;
    n = 0;
    #1;
    while (cpu_halt_o === 1'b1) begin
      n++;
      if (n > 5000) begin
        miscompares++;
        $display("FAIL halt length expected end seen timeout");
        test_done;
      end
      @(posedge core_clk_i);
      #1;
    end
  endtask
  task automatic wake;
    @(posedge core_clk_i);
    wake_i <= 1'b1;
    @(posedge core_clk_i);
    wake_i <= 1'b0;
    halt_len;
  endtask
  task automatic flags(input string what, input logic [2:0] exp);
    chk(what, {13'h0000, exp}, {13'h0000, stop_mode_o, main_pll_run_o, sub_pll_run_o});
  endtask
  task automatic test_done;
    $display("Checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    reset_i = 1'b1;
    reg_write_i = 1'b0;
    reg_read_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 16'h0000;
    wake_i = 1'b0;
    repeat (16) @(posedge core_clk_i);
    reset_i <= 1'b0;
    #1 chk("halt in reset", 16'h0001, {15'h0000, cpu_halt_o});
    flags("runs in reset", 3'b000);
    halt_len;
    chk("reset wait", 16'h0001, 16'(n >= 255 && n <= 258));
    rdr(clock_source_addr);
    chk("clock source reset", clock_source_reset, rd);
    rdr(standby_control_addr);
    chk("standby reset", standby_control_reset, rd);
    $display("Reset test done");
    // Rows cover refused selects, ignored disables, enables and an unmapped place.
    foreach (rows[i]) begin
      if (i == 2) repeat (300) @(posedge core_clk_i);
      wr(rows[i].a, rows[i].w);
      rdr(rows[i].a);
      chk("row readback", rows[i].r, rd);
      chk("row flags", {13'h0000, rows[i].f},
        {13'h0000, cpu_halt_o, main_pll_run_o, sub_pll_run_o});
    end
    $display("Row tests done");
    wr(clock_source_addr, 16'h6C01);
    halt_len;
    chk("rate wait", 16'd256, 16'(n));
    chk("rate out", 16'h0006, {13'h0000, pll_rate_o});
    wr(clock_source_addr, 16'h6C00);
    wr(clock_source_addr, 16'h7C00);
    halt_len;
    chk("no wait off pll", 16'h0000, 16'(n));
    $display("Rate tests done");
    wr(standby_control_addr, 16'h0083);
    #1 flags("stop halted", 3'b100);
    wake;
    chk("stop return wait", 16'd256, 16'(n));
    flags("stop restart", 3'b011);
    wr(standby_control_addr, 16'h0088);
    #1 flags("stop running", 3'b111);
    wake;
    chk("selected wait", 16'd1024, 16'(n));
    wr(standby_control_addr, 16'h0080);
    wake;
    chk("minimum wait", 16'd256, 16'(n));
    $display("Stop tests done");
    // Sub source: status shows it, and the base clock follows its halves.
    wr(clock_source_addr, 16'h7C02);
    repeat (4) @(posedge core_clk_i);
    rdr(clock_status_addr);
    chk("status on sub", 16'h002C, rd);
    n = 0;
    repeat (64) begin
      rd[0] = base_clk_o;
      @(posedge core_clk_i);
      #1 if (base_clk_o !== rd[0]) n++;
    end
    chk("sub halves", 16'h0001, 16'(n >= 15 && n <= 17));
    wr(clock_source_addr, 16'h7C00);
    repeat (16) @(posedge core_clk_i);
    $display("Source test done");
    // Channel 0 divides by six halves, a period of twelve core cycles.
    n = 0;
    repeat (120) begin
      @(posedge core_clk_i);
      #1 if (clk_tick_o[0] === 1'b1) begin
        n++;
        chk("level at tick", 16'h0001, {15'h0000, clk_level_o[0]});
      end
    end
    chk("divided ticks", 16'h0001, 16'(n >= 9 && n <= 11));
    $display("Divider test done");
    test_done;
  end
endmodule // tb
